// ---- hdl/usr_shift_top.sv ----
// Four-stage bidirectional universal shift register with pin and APB control.
`timescale 1ns/1ns
`default_nettype none
module usr_shift_top
  import usr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic pin_clock,
  input wire logic pin_clear_n,
  input wire logic mode_sel_lo,
  input wire logic mode_sel_hi,
  input wire logic ser_right_in,
  input wire logic ser_left_in,
  input wire logic [USR_WIDTH-1:0] par_in,
  output logic stage_first_out,
  output logic stage_second_out,
  output logic stage_third_out,
  output logic stage_last_out
);

  // The stage outputs are named one by one, so the width is fixed.
  if (USR_WIDTH != 4) begin : g_bad_width
    $error("usr_shift_top serves exactly four stages");
  end

  usr_pins_s pins_raw;
  usr_pins_s pins_sync;
  usr_drive_s pin_drive;
  usr_drive_s sw_drive;
  usr_drive_s drive;
  logic pin_clk_prev_reg;
  logic pin_tick;
  logic tick;
  logic [5:0] ctrl_reg;
  logic [USR_WIDTH-1:0] data_reg;
  logic step_pulse_reg;
  logic clear_hold_reg;
  logic clear_req;
  logic stage_rst_n;
  logic [USR_WIDTH-1:0] stage_reg;
  logic [USR_WIDTH-1:0] stage_next;
  logic [USR_WIDTH-1:0] shr_val;
  logic [USR_WIDTH-1:0] shl_val;
  logic [15:0] cnt_reg;
  logic is_load;
  logic is_right;
  logic is_left;
  logic is_hold;
  logic sw_src;
  logic acc;
  logic wr_commit;
  logic hit_ctrl;
  logic hit_data;
  logic hit_step;
  logic hit_stat;
  logic hit_cnt;
  logic hit_any;
  logic [31:0] rdata_mux;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // Board pins are bundled and brought into the pclk domain before any logic reads them.
  assign pins_raw = '{clock: pin_clock, clear_n: pin_clear_n, mode: {mode_sel_hi, mode_sel_lo},
                      ser_right: ser_right_in, ser_left: ser_left_in, par: par_in};

  usr_sync #(
    .WIDTH($bits(usr_pins_s)),
    .RST_VAL(USR_PINS_IDLE)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // Pin clock edge detect; data travels the same two flops, so it lines up with the edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_clk_prev_reg <= 1'b0;
    end else begin
      pin_clk_prev_reg <= pins_sync.clock;
    end
  end

  assign pin_tick = pins_sync.clock & ~pin_clk_prev_reg;

  // Drive selection: software may take over mode, serial and parallel data and step the clock itself.
  assign pin_drive = '{mode: usr_mode_e'(pins_sync.mode), ser_right: pins_sync.ser_right,
                       ser_left: pins_sync.ser_left, par: pins_sync.par};
  assign sw_drive = '{mode: usr_mode_e'(ctrl_reg[USR_CTRL_MODE_LSB +: 2]), ser_right: ctrl_reg[USR_CTRL_SER_R_BIT],
                      ser_left: ctrl_reg[USR_CTRL_SER_L_BIT], par: data_reg};
  assign sw_src = ctrl_reg[USR_CTRL_SRC_BIT];
  assign drive = sw_src ? sw_drive : pin_drive;
  assign tick = sw_src ? step_pulse_reg : pin_tick;

  // Mode decode; the four cases cover the two-bit code with no overlap.
  assign is_load = (drive.mode == USR_MODE_LOAD);
  assign is_right = (drive.mode == USR_MODE_RIGHT);
  assign is_left = (drive.mode == USR_MODE_LEFT);
  assign is_hold = (drive.mode == USR_MODE_HOLD);

  // Shift values; bit 0 is the first stage and bit 3 the last.
  assign shr_val = {stage_reg[USR_WIDTH-2:0], drive.ser_right};
  assign shl_val = {drive.ser_left, stage_reg[USR_WIDTH-1:1]};

  // Load ignores the serial inputs, hold and idle cycles keep the stages.
  assign stage_next = !tick ? stage_reg :
                      is_load ? drive.par :
                      is_right ? shr_val :
                      is_left ? shl_val :
                      stage_reg;

  // Clear from the pin or from software; either one holds the stages in reset.
  assign clear_req = ~pins_sync.clear_n | ctrl_reg[USR_CTRL_SCLR_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_hold_reg <= 1'b0;
    end else begin
      clear_hold_reg <= clear_req;
    end
  end

  // The registered clear reaches the stages through their asynchronous reset, so no further clock edge is needed.
  assign stage_rst_n = presetn & ~clear_hold_reg;

  // Stage flops; the clear overrides mode, tick and data for as long as it stands.
  always_ff @(posedge pclk or negedge stage_rst_n) begin
    if (!stage_rst_n) begin
      stage_reg <= USR_STAGE_RST;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign stage_first_out = stage_reg[0];
  assign stage_second_out = stage_reg[1];
  assign stage_third_out = stage_reg[2];
  assign stage_last_out = stage_reg[USR_WIDTH-1];

  // Count of clocking edges that moved or loaded data; it wraps and is cleared with the stages.
  always_ff @(posedge pclk or negedge stage_rst_n) begin
    if (!stage_rst_n) begin
      cnt_reg <= USR_CNT_RST;
    end else if (tick && !is_hold) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // APB decode; the slave inserts one wait state so read data comes from a flop.
  assign acc = psel & penable;
  assign wr_commit = acc & pwrite & pready_reg;
  assign hit_ctrl = (paddr == USR_CTRL_OFF);
  assign hit_data = (paddr == USR_DATA_OFF);
  assign hit_step = (paddr == USR_STEP_OFF);
  assign hit_stat = (paddr == USR_STAT_OFF);
  assign hit_cnt = (paddr == USR_CNT_OFF);
  assign hit_any = hit_ctrl | hit_data | hit_step | hit_stat | hit_cnt;

  // Read mux; the step register reads as zero and unmapped addresses read as zero.
  assign rdata_mux = hit_ctrl ? {26'h0, ctrl_reg} :
                     hit_data ? {28'h0000000, data_reg} :
                     hit_stat ? {23'h0, clear_hold_reg, 4'h0, stage_reg} :
                     hit_cnt ? {16'h0000, cnt_reg} :
                     32'h00000000;

  // Answer flops: pready rises one cycle into the access phase and falls after the handshake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= acc & ~pready_reg;
      prdata_reg <= (acc & ~pready_reg & ~pwrite) ? rdata_mux : 32'h00000000;
      pslverr_reg <= acc & ~pready_reg & ~hit_any;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // Writable registers take effect only at the handshake edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= USR_CTRL_RST;
      data_reg <= USR_DATA_RST;
    end else if (wr_commit) begin
      if (hit_ctrl) begin
        ctrl_reg <= pwdata[5:0];
      end
      if (hit_data) begin
        data_reg <= pwdata[USR_WIDTH-1:0];
      end
    end
  end

  // With software drive selected, a step write with the go bit set gives exactly one clocking edge, at most one per bus transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pulse_reg <= 1'b0;
    end else begin
      step_pulse_reg <= wr_commit & hit_step & pwdata[USR_STEP_GO_BIT];
    end
  end

  // Helper for the far-end check: a record of the serial bits taken by unbroken shifts; hold edges move neither.
  logic [USR_WIDTH-1:0] hist_r_reg;
  logic [USR_WIDTH-1:0] hist_l_reg;
  logic [2:0] run_r_reg;
  logic [2:0] run_l_reg;

  always_ff @(posedge pclk or negedge stage_rst_n) begin
    if (!stage_rst_n) begin
      hist_r_reg <= '0;
      hist_l_reg <= '0;
      run_r_reg <= 3'h0;
      run_l_reg <= 3'h0;
    end else if (tick) begin
      if (is_right) begin
        hist_r_reg <= {hist_r_reg[USR_WIDTH-2:0], drive.ser_right};
      end
      if (is_left) begin
        hist_l_reg <= {drive.ser_left, hist_l_reg[USR_WIDTH-1:1]};
      end
      run_r_reg <= (is_right || is_hold) ? ((run_r_reg == 3'h4 || !is_right) ? run_r_reg : run_r_reg + 3'h1) : 3'h0;
      run_l_reg <= (is_left || is_hold) ? ((run_l_reg == 3'h4 || !is_left) ? run_l_reg : run_l_reg + 3'h1) : 3'h0;
    end
  end

  // Exactly one mode is decoded at all times.
  property p_one_mode;
    @(posedge pclk) disable iff (!presetn)
    $onehot({is_load, is_right, is_left, is_hold});
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode decode not one-hot");

  // A load edge leaves the parallel word in the stages.
  property p_load;
    @(posedge pclk) disable iff (!presetn)
    (tick && is_load && !clear_hold_reg) |=> (clear_hold_reg || stage_reg == $past(drive.par));
  endproperty
  a_load: assert property (p_load) else $error("parallel load lost");

  // During a load the first stage follows the data, not the right serial input.
  property p_load_no_serial;
    @(posedge pclk) disable iff (!presetn)
    (tick && is_load && !clear_hold_reg && drive.ser_right != drive.par[0])
      |=> (clear_hold_reg || stage_reg[0] != $past(drive.ser_right));
  endproperty
  a_load_no_serial: assert property (p_load_no_serial) else $error("serial data entered during load");

  // Shift toward the last stage.
  property p_right;
    @(posedge pclk) disable iff (!presetn)
    (tick && is_right && !clear_hold_reg)
      |=> (clear_hold_reg || stage_reg == {$past(stage_reg[2:0]), $past(drive.ser_right)});
  endproperty
  a_right: assert property (p_right) else $error("right shift wrong");

  // Shift toward the first stage.
  property p_left;
    @(posedge pclk) disable iff (!presetn)
    (tick && is_left && !clear_hold_reg)
      |=> (clear_hold_reg || stage_reg == {$past(drive.ser_left), $past(stage_reg[3:1])});
  endproperty
  a_left: assert property (p_left) else $error("left shift wrong");

  // Hold mode keeps the stages even on a clocking edge.
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (tick && is_hold && !clear_hold_reg) |=> (clear_hold_reg || $stable(stage_reg));
  endproperty
  a_hold: assert property (p_hold) else $error("stages moved in hold");

  // A standing clear keeps every stage low for as long as it lasts.
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    clear_hold_reg [*2] |-> (stage_reg == 4'h0 && cnt_reg == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("stages not held low by clear");

  // After four unbroken shift edges toward it the last stage shows the bit taken four shifts back.
  property p_far_end;
    @(posedge pclk) disable iff (!presetn)
    (run_r_reg == 3'h4 && !clear_hold_reg) |-> (stage_reg[3] == hist_r_reg[3]);
  endproperty
  a_far_end: assert property (p_far_end) else $error("serial bit missing at last stage");

  // The same for the left serial input, seen at the first stage.
  property p_far_end_first;
    @(posedge pclk) disable iff (!presetn)
    (run_l_reg == 3'h4 && !clear_hold_reg) |-> (stage_reg[0] == hist_l_reg[0]);
  endproperty
  a_far_end_first: assert property (p_far_end_first) else $error("serial bit missing at first stage");

  // Without a clocking edge nothing moves.
  property p_idle;
    @(posedge pclk) disable iff (!presetn)
    (!tick && !clear_hold_reg) |=> (clear_hold_reg || $stable(stage_reg));
  endproperty
  a_idle: assert property (p_idle) else $error("stages moved without a clock edge");

  // The bus answer stands for exactly one cycle, one cycle into the access phase.
  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    $rose(acc) |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong");

endmodule // usr_shift_top
`default_nettype wire

// ---- pkg/usr_pkg.sv ----
// Shared constants, mode encoding and carrier types of the universal shift register.
`default_nettype none
package usr_pkg;

  // Number of register stages.
  localparam int USR_WIDTH = 4;

  // Register byte offsets on the APB.
  localparam logic [11:0] USR_CTRL_OFF = 12'h000;
  localparam logic [11:0] USR_DATA_OFF = 12'h004;
  localparam logic [11:0] USR_STEP_OFF = 12'h008;
  localparam logic [11:0] USR_STAT_OFF = 12'h00c;
  localparam logic [11:0] USR_CNT_OFF = 12'h010;

  // Control register field positions.
  localparam int USR_CTRL_SRC_BIT = 0;
  localparam int USR_CTRL_SCLR_BIT = 1;
  localparam int USR_CTRL_MODE_LSB = 2;
  localparam int USR_CTRL_SER_R_BIT = 4;
  localparam int USR_CTRL_SER_L_BIT = 5;

  // Step register field and status register field positions.
  localparam int USR_STEP_GO_BIT = 0;
  localparam int USR_STAT_CLEAR_BIT = 8;

  // Reset values.
  localparam logic [5:0] USR_CTRL_RST = 6'h00;
  localparam logic [3:0] USR_DATA_RST = 4'h0;
  localparam logic [3:0] USR_STAGE_RST = 4'h0;
  localparam logic [15:0] USR_CNT_RST = 16'h0000;

  // Operating modes, coded as {mode_sel_hi, mode_sel_lo}.
  typedef enum logic [1:0] {
    USR_MODE_HOLD = 2'h0,
    USR_MODE_RIGHT = 2'h1,
    USR_MODE_LEFT = 2'h2,
    USR_MODE_LOAD = 2'h3
  } usr_mode_e;

  // Raw pin group as it arrives from the board.
  typedef struct packed {
    logic clock;
    logic clear_n;
    logic [1:0] mode;
    logic ser_right;
    logic ser_left;
    logic [USR_WIDTH-1:0] par;
  } usr_pins_s;

  // Idle level of the pin group; the synchroniser resets to it so that no false clear or edge follows reset.
  localparam usr_pins_s USR_PINS_IDLE = '{clock: 1'b0, clear_n: 1'b1, mode: 2'h0, ser_right: 1'b0,
                                          ser_left: 1'b0, par: '0};

  // Drive that actually steers the stages, from pins or from software.
  typedef struct packed {
    usr_mode_e mode;
    logic ser_right;
    logic ser_left;
    logic [USR_WIDTH-1:0] par;
  } usr_drive_s;

endpackage
`default_nettype wire

// ---- hdl/usr_sync.sv ----
// Two-flop level synchroniser for a bundle of asynchronous pin inputs.
`timescale 1ns/1ns
`default_nettype none
module usr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // A zero width bundle makes no hardware and hides a wiring slip.
  if (WIDTH < 1) begin : g_bad_width
    $error("usr_sync needs WIDTH of at least 1");
  end

  // The first flop is read only by the second, so a metastable value never fans out.
  // Both flops reset to the idle level of their pins, so reset never looks like a pin event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // usr_sync
`default_nettype wire

// ---- bench/usr_board_model.sv ----
// Board-side driver model that clocks the pin group of the shift register.
`timescale 1ns/1ns
`default_nettype none
module usr_board_model
  import usr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic req_clr,
  input wire logic slow,
  input var usr_drive_s req_drv,
  output logic done,
  output var usr_pins_s pins
);
  int unsigned cnt;
  int unsigned gap;

  // A slow board stretches every phase so the sampling path sees wider margins.
  assign gap = slow ? 5 : 3;

  // One request walks data setup, a rising pin clock, its low phase and the clear release.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      done <= 1'b0;
      pins <= usr_pins_s'{clear_n: 1'b1, default: '0};
    end else if (cnt == 0) begin
      done <= 1'b0;
      if (req && !done) begin
        cnt <= 1;
        pins <= usr_pins_s'{clock: 1'b0, clear_n: !req_clr, mode: req_drv.mode, ser_right: req_drv.ser_right,
                            ser_left: req_drv.ser_left, par: req_drv.par};
      end else begin
        // Idle data lines hold no promised value, so they toggle to expose any stray capture.
        pins.par <= ~pins.par;
        pins.ser_right <= ~pins.ser_right;
        pins.ser_left <= ~pins.ser_left;
      end
    end else begin
      cnt <= cnt + 1;
      if (cnt == gap) pins.clock <= 1'b1;
      if (cnt == 2 * gap) pins.clock <= 1'b0;
      if (cnt == 3 * gap) pins.clear_n <= 1'b1;
      if (cnt == 4 * gap) begin
        cnt <= 0;
        done <= 1'b1;
      end
    end
  end
endmodule // usr_board_model
`default_nettype wire

// ---- bench/test_bidir_universal_shift_register.sv ----
// Self-checking bench of the universal shift register against a behavioural model.
`timescale 1ns/1ns
`default_nettype none
module test_bidir_universal_shift_register
  import usr_pkg::*;
  ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr;
  logic [31:0] prdata;
  logic s1, s2, s3, s4;
  wire logic [3:0] outs = {s4, s3, s2, s1};
  logic req = 1'b0;
  logic req_clr = 1'b0;
  logic slow = 1'b0;
  logic done;
  logic sw = 1'b0;
  usr_drive_s req_drv = '0;
  usr_pins_s pins;
  int mismatches = 0;
  int tests_run = 0;
  int mstage = 0;
  int mcnt = 0;
  logic [31:0] seed = 32'h0000_8bf8;

  // The clock toggles every half period of 25 ns.
  always #25 pclk = ~pclk;

  usr_board_model usr_board_model_inst (.pclk(pclk), .presetn(presetn), .req(req), .req_clr(req_clr),
    .slow(slow), .req_drv(req_drv), .done(done), .pins(pins));

  usr_shift_top usr_shift_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_clock(pins.clock), .pin_clear_n(pins.clear_n), .mode_sel_lo(pins.mode[0]), .mode_sel_hi(pins.mode[1]),
    .ser_right_in(pins.ser_right), .ser_left_in(pins.ser_left), .par_in(pins.par),
    .stage_first_out(s1), .stage_second_out(s2), .stage_third_out(s3), .stage_last_out(s4));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic usr_drive_s rand_drive(input logic [1:0] m);
    logic [31:0] r;
    r = rnd();
    return '{mode: usr_mode_e'(m), ser_right: r[4], ser_left: r[5], par: r[3:0]};
  endfunction

  // Reference model of one clocking edge.
  function automatic int mstep(input int s, input usr_drive_s d);
    case (d.mode)
      USR_MODE_RIGHT: return ((s << 1) & 14) | int'(d.ser_right);
      USR_MODE_LEFT: return (s >> 1) | (int'(d.ser_left) << 3);
      USR_MODE_LOAD: return int'(d.par);
      default: return s;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The request stands until pready is sampled high at a rising edge; answer taken and request dropped there.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rdv,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One board request, then the model follows; while software owns the stages it follows only a clear.
  task automatic pulse(input usr_drive_s d, input logic clr);
    @(posedge pclk);
    req_drv <= d;
    req_clr <= clr;
    req <= 1'b1;
    do begin
      @(posedge pclk);
    end while (done !== 1'b1);
    req <= 1'b0;
    if (clr) begin
      mstage = 0;
      mcnt = 0;
    end else if (!sw) begin
      mstage = mstep(mstage, d);
      if (d.mode != USR_MODE_HOLD) mcnt = (mcnt + 1) % 65536;
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset, pin traffic, far-end runs, clear, software drive, refusals.
  initial begin
    usr_drive_s d;
    logic [31:0] rdv;
    logic err;
    int far_q[$];
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("outs_rst", {28'h0000000, outs}, 32'h0000_0000);
    apb(1'b0, USR_CTRL_OFF, 32'h0, rdv, err);
    check("ctrl_rst", rdv, {26'h0, USR_CTRL_RST});
    check("ctrl_rst_err", {31'h0, err}, 32'h0000_0000);
    apb(1'b0, USR_DATA_OFF, 32'h0, rdv, err);
    check("data_rst", rdv, {28'h0, USR_DATA_RST});
    apb(1'b0, USR_CNT_OFF, 32'h0, rdv, err);
    check("cnt_rst", rdv, {16'h0, USR_CNT_RST});
    for (int i = 0; i < 40; i++) begin
      slow <= i[3];
      pulse(rand_drive(i[1:0]), 1'b0);
      check("stages", {28'h0000000, outs}, 32'(mstage));
    end
    for (int dir = 0; dir < 2; dir++) begin
      d = '0;
      d.mode = USR_MODE_LOAD;
      pulse(d, 1'b0);
      // The far-end stage shows the serial bit taken four shifts back; the load left four zeros.
      far_q = '{0, 0, 0, 0};
      for (int k = 0; k < 4; k++) begin
        d.mode = dir ? USR_MODE_LEFT : USR_MODE_RIGHT;
        d.ser_right = (k == 0);
        d.ser_left = (k == 0);
        pulse(d, 1'b0);
        far_q.push_back(int'(k == 0));
        void'(far_q.pop_front());
        check("far_end", {31'h0, dir ? s1 : s4}, 32'(far_q[0]));
      end
    end
    apb(1'b0, USR_CNT_OFF, 32'h0, rdv, err);
    check("cnt", rdv, 32'(mcnt));
    pulse(rand_drive(2'h3), 1'b1);
    check("clear", {28'h0000000, outs}, 32'h0000_0000);
    apb(1'b0, USR_CNT_OFF, 32'h0, rdv, err);
    check("cnt_clr", rdv, 32'h0000_0000);
    sw = 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = rand_drive(i[1:0]);
      apb(1'b1, USR_DATA_OFF, {28'h0, d.par}, rdv, err);
      apb(1'b1, USR_CTRL_OFF, {26'h0, d.ser_left, d.ser_right, d.mode, 1'b0, 1'b1}, rdv, err);
      apb(1'b1, USR_STEP_OFF, 32'h0000_0001, rdv, err);
      mstage = mstep(mstage, d);
      apb(1'b0, USR_STAT_OFF, 32'h0, rdv, err);
      check("stat", rdv, 32'(mstage));
    end
    apb(1'b0, USR_CTRL_OFF, 32'h0, rdv, err);
    check("ctrl_rd", rdv, {26'h0, d.ser_left, d.ser_right, d.mode, 1'b0, 1'b1});
    pulse(rand_drive(2'h3), 1'b0);
    check("pins_ignored", {28'h0000000, outs}, 32'(mstage));
    apb(1'b1, USR_CTRL_OFF, 32'h0000_0003, rdv, err);
    apb(1'b0, USR_STAT_OFF, 32'h0, rdv, err);
    check("soft_clear", rdv, 32'h0000_0100);
    apb(1'b1, 12'h020, 32'h0000_003d, rdv, err);
    check("unmapped_wr_err", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h014, 32'h0, rdv, err);
    check("unmapped_rd_err", {31'h0, err}, 32'h0000_0001);
    check("unmapped_rd", rdv, 32'h0000_0000);
    apb(1'b0, USR_CTRL_OFF, 32'h0, rdv, err);
    check("ctrl_kept", rdv, 32'h0000_0003);
    // A reset in mid-run returns the registers to their reset values and raises no clear.
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, USR_CTRL_OFF, 32'h0, rdv, err);
    check("ctrl_mid_rst", rdv, {26'h0, USR_CTRL_RST});
    apb(1'b0, USR_STAT_OFF, 32'h0, rdv, err);
    check("stat_mid_rst", rdv, 32'h0000_0000);
    report_and_stop();
  end

  // Watchdog against a hung handshake.
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule // test_bidir_universal_shift_register
`default_nettype wire
